//--- rtl/alm_core.sv
// Executor for xor, rotate-through-carry and move instructions of an 8-bit core
// Operation
// - XOR accumulator into direct byte, 2B/2C
// - XOR immediate into direct byte, 3B/3C
// - XOR indirect RAM into accumulator, 1B/2C
// - XOR immediate into accumulator, 2B/2C
// - Rotate left through carry, 1B/1C
// - Rotate right through carry, 1B/1C
// - Load accumulator from direct byte, 2B/2C
// - Load accumulator from indirect RAM, 1B/2C
// - Copy direct byte to working register, 2B/2C
// - Load immediate into working register, 2B/2C
// - Store accumulator to direct byte, 2B/2C
// - Store working register to direct byte
// - Copy direct byte to direct byte, 3B/3C
`timescale 1ns/10ps
module alm_core
    import alm_pkg::*;
#(
    parameter int unsigned CAW = CODE_AW
) (
    input  wire logic             core_clk,
    input  wire logic             srst,
    output logic [CAW-1:0]        code_addr,
    output logic                  code_rd,
    input  wire logic [7:0]       code_data,
    output logic [7:0]            dmem_raddr,
    output logic                  dmem_rd,
    input  wire logic [7:0]       dmem_rdata,
    output alm_wr_s               dmem_wr,
    output logic [7:0]            acc,
    output logic                  carry,
    output logic                  instr_done,
    output logic                  illegal_op
);

    // ****************************************
    // State
    // ****************************************
    alm_ph_e    ph;
    alm_cls_e   cls;
    logic [7:0] opc;
    logic [7:0] adr1;
    logic [7:0] wreg [WREG_NUM];

    alm_ph_e    next_ph;
    logic [7:0] next_acc;
    logic       next_cy;
    alm_wr_s    next_wr;
    logic       wreg_we;
    logic [7:0] wreg_wd;

    // ****************************************
    // Decode and sequencing
    // ****************************************
    wire logic       start   = ph == PH_OP;
    wire alm_cls_e   dec_cls = alm_decode(code_data);
    wire alm_cls_e   cur_cls = start ? dec_cls : cls;
    wire logic [7:0] cur_op  = start ? code_data : opc;
    wire alm_len_s   len     = alm_length(cur_cls);
    wire logic [1:0] cyc_idx = ph[2] ? 2'd2 : (ph[1] ? 2'd1 : 2'd0);
    wire logic [2:0] wsel    = cur_op[WSEL_LSB +: 3];
    wire logic [7:0] ptr_val = wreg[{2'b00, cur_op[PSEL_BIT]}];
    wire logic [7:0] wval    = wreg[wsel];

    wire logic last = cyc_idx == (len.ncyc - 2'd1);
    assign code_rd    = cyc_idx < len.nbytes;
    assign instr_done = last;
    assign illegal_op = start && dec_cls == C_NOP;
    assign next_ph    = last ? PH_OP : (start ? PH_B1 : PH_B2);

    // ****************************************
    // Operand read selection
    // ****************************************
    // pointer addressed read
    wire logic rd_ptr  = cur_cls inside {C_XAM, C_MAI};
    wire logic rd_adr1 = cur_cls inside {C_XDI, C_MDD};
    wire logic rd_dir  = cur_cls inside {C_XDA, C_MAD, C_MRD};
    assign dmem_rd    = (ph == PH_B1 && (rd_ptr || rd_dir)) || (ph == PH_B2 && rd_adr1);
    assign dmem_raddr = rd_ptr ? ptr_val : (rd_adr1 ? adr1 : code_data);

    // ****************************************
    // Execution
    // ****************************************
    always_comb begin
        next_acc = acc;
        next_cy  = carry;
        next_wr  = '0;
        wreg_we  = 1'b0;
        wreg_wd  = dmem_rdata;
        if (last) begin
            unique case (cur_cls)
                C_NOP: ;
                C_XDA: next_wr = '{we: 1'b1, addr: code_data, data: dmem_rdata ^ acc};
                C_XDI: next_wr = '{we: 1'b1, addr: adr1, data: dmem_rdata ^ code_data};
                C_XAM: next_acc = acc ^ dmem_rdata;
                C_XAI: next_acc = acc ^ code_data;
                C_ROL: begin
                    next_acc = {acc[6:0], carry};
                    next_cy  = acc[7];
                end
                C_ROR: begin
                    next_acc = {carry, acc[7:1]};
                    next_cy  = acc[0];
                end
                C_MAD, C_MAI: next_acc = dmem_rdata;
                C_MRD: wreg_we = 1'b1;
                C_MRI: begin
                    wreg_we = 1'b1;
                    wreg_wd = code_data;
                end
                C_MDA: next_wr = '{we: 1'b1, addr: code_data, data: acc};
                C_MDR: next_wr = '{we: 1'b1, addr: code_data, data: wval};
                C_MDD: next_wr = '{we: 1'b1, addr: code_data, data: dmem_rdata};
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    // Write lands one cycle late; next read is never before cycle 1
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ph        <= PH_OP;
            code_addr <= '0;
            acc       <= ACC_RST;
            carry     <= 1'b0;
            dmem_wr   <= '0;
        end else begin
            ph      <= next_ph;
            acc     <= next_acc;
            carry   <= next_cy;
            dmem_wr <= next_wr;
            if (code_rd) begin
                code_addr <= code_addr + CAW'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (start) begin
            cls <= dec_cls;
            opc <= code_data;
        end
        if (ph == PH_B1) begin
            adr1 <= code_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < WREG_NUM; i++) begin
                wreg[i] <= WREG_RST;
            end
        end else if (wreg_we) begin
            wreg[wsel] <= wreg_wd;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    logic [1:0] nfetch;
    wire logic [1:0] fetched = (start ? 2'd0 : nfetch) + {1'b0, code_rd};
    always_ff @(posedge core_clk) begin
        nfetch <= srst ? 2'd0 : fetched;
    end

    AST_XDA: assert property (
        start && dec_cls == C_XDA |=> instr_done && code_rd ##1
        dmem_wr.we && dmem_wr.addr == $past(code_data)
        && dmem_wr.data == ($past(dmem_rdata) ^ acc))
        else $error("xor into direct byte wrong");

    AST_XDI: assert property (
        start && dec_cls == C_XDI |=> !instr_done ##1 instr_done ##1
        dmem_wr.we && dmem_wr.addr == $past(code_data, 2))
        else $error("xor immediate into direct byte wrong");

    AST_XAM: assert property (
        start && dec_cls == C_XAM |=> !code_rd && instr_done && dmem_rd ##1
        acc == ($past(acc) ^ $past(dmem_rdata)))
        else $error("xor indirect into accumulator wrong");

    AST_XAI: assert property (
        start && dec_cls == C_XAI |=> instr_done ##1
        acc == ($past(acc) ^ $past(code_data)))
        else $error("xor immediate into accumulator wrong");

    AST_ROL: assert property (
        start && dec_cls == C_ROL |-> instr_done ##1
        carry == $past(acc[7]) && acc == {$past(acc[6:0]), $past(carry)})
        else $error("rotate left through carry wrong");

    AST_ROR: assert property (
        start && dec_cls == C_ROR |-> instr_done ##1
        carry == $past(acc[0]) && acc == {$past(carry), $past(acc[7:1])})
        else $error("rotate right through carry wrong");

    AST_MAD: assert property (
        start && dec_cls == C_MAD |=> instr_done && dmem_raddr == code_data ##1
        acc == $past(dmem_rdata))
        else $error("load accumulator from direct wrong");

    AST_MAI: assert property (
        start && dec_cls == C_MAI |=> !code_rd && dmem_raddr == ptr_val ##1
        acc == $past(dmem_rdata) && start)
        else $error("load accumulator from indirect wrong");

    AST_MDA: assert property (
        start && dec_cls == C_MDA |=> instr_done ##1
        dmem_wr.we && dmem_wr.data == acc && dmem_wr.addr == $past(code_data))
        else $error("store accumulator wrong");

    AST_MDD: assert property (
        start && dec_cls == C_MDD |=> !instr_done ##1
        instr_done && dmem_raddr == $past(code_data) ##1
        dmem_wr.we && dmem_wr.data == $past(dmem_rdata))
        else $error("direct to direct copy wrong");

    AST_FETCH: assert property (
        instr_done |-> fetched == len.nbytes ##1 start)
        else $error("instruction ended with wrong byte count");

    AST_PC: assert property (
        start ##1 !start |-> code_addr == $past(code_addr) + CAW'(1))
        else $error("program counter did not advance");

    // Opcode register still holds the finished instruction one cycle on
    AST_MRD: assert property (
        start && dec_cls == C_MRD |=> instr_done && dmem_rd && dmem_raddr == code_data ##1
        wreg[opc[WSEL_LSB +: 3]] == $past(dmem_rdata))
        else $error("direct byte to working register wrong");

    AST_MRI: assert property (
        start && dec_cls == C_MRI |=> instr_done && code_rd ##1
        wreg[opc[WSEL_LSB +: 3]] == $past(code_data))
        else $error("immediate to working register wrong");

    AST_MDR: assert property (
        start && dec_cls == C_MDR |=> instr_done ##1
        dmem_wr.we && dmem_wr.addr == $past(code_data)
        && dmem_wr.data == wreg[opc[WSEL_LSB +: 3]])
        else $error("store working register wrong");

    // Unknown opcodes must not stall the fetch or touch state
    AST_ILL: assert property (
        illegal_op |-> instr_done && code_rd ##1
        start && !dmem_wr.we && $stable(acc) && $stable(carry))
        else $error("unknown opcode not a one-cycle no-op");

    CVR_XDI: cover property (start && dec_cls == C_XDI ##3 dmem_wr.we);
    CVR_MDD: cover property (start && dec_cls == C_MDD ##3 dmem_wr.we);
    CVR_ROL: cover property (start && dec_cls == C_ROL ##1 start && dec_cls == C_ROR);
    CVR_MAI: cover property (start && dec_cls == C_MAI ##2 start && dec_cls == C_MAD);
    CVR_ILL: cover property (illegal_op ##1 illegal_op);

endmodule // alm_core

//--- rtl/alm_pkg.sv
// Opcodes, instruction classes, lengths and carrier types of the accumulator executor
package alm_pkg;

    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int unsigned CODE_AW   = 16;
    localparam logic [7:0]  ACC_RST   = 8'h00;
    localparam logic [7:0]  WREG_RST  = 8'h00;
    localparam int unsigned WREG_NUM  = 8;
    localparam int unsigned WSEL_LSB  = 0;
    localparam int unsigned PSEL_BIT  = 0;

    // ****************************************
    // Opcode encodings
    // ****************************************
    localparam logic [7:0] OP_XOR_DA  = 8'h10;
    localparam logic [7:0] OP_XOR_DI  = 8'h11;
    localparam logic [7:0] OP_XOR_AM  = 8'h12;
    localparam logic [7:0] OP_XOR_AI  = 8'h14;
    localparam logic [7:0] OP_ROTL    = 8'h20;
    localparam logic [7:0] OP_ROTR    = 8'h21;
    localparam logic [7:0] OP_MOVE_AD = 8'h30;
    localparam logic [7:0] OP_MOVE_AM = 8'h32;
    localparam logic [7:0] OP_MOVE_RD = 8'h40;
    localparam logic [7:0] OP_MOVE_RI = 8'h48;
    localparam logic [7:0] OP_MOVE_DA = 8'h50;
    localparam logic [7:0] OP_MOVE_DR = 8'h58;
    localparam logic [7:0] OP_MOVE_DD = 8'h60;
    localparam logic [7:0] MSK_PSEL   = 8'hFE;
    localparam logic [7:0] MSK_WSEL   = 8'hF8;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [3:0] {
        C_NOP, C_XDA, C_XDI, C_XAM, C_XAI, C_ROL, C_ROR,
        C_MAD, C_MAI, C_MRD, C_MRI, C_MDA, C_MDR, C_MDD
    } alm_cls_e;

    typedef enum logic [2:0] {
        PH_OP = 3'b001,
        PH_B1 = 3'b010,
        PH_B2 = 3'b100
    } alm_ph_e;

    typedef struct packed {
        logic [1:0] nbytes;
        logic [1:0] ncyc;
    } alm_len_s;

    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] data;
    } alm_wr_s;

    // Bytes and cycles per instruction
    localparam alm_len_s L_1B1C = '{nbytes: 2'd1, ncyc: 2'd1};
    localparam alm_len_s L_1B2C = '{nbytes: 2'd1, ncyc: 2'd2};
    localparam alm_len_s L_2B2C = '{nbytes: 2'd2, ncyc: 2'd2};
    localparam alm_len_s L_3B3C = '{nbytes: 2'd3, ncyc: 2'd3};

    function automatic alm_cls_e alm_decode(input logic [7:0] op);
        alm_cls_e c;
        c = C_NOP;
        if (op == OP_XOR_DA) c = C_XDA;
        if (op == OP_XOR_DI) c = C_XDI;
        if ((op & MSK_PSEL) == OP_XOR_AM) c = C_XAM;
        if (op == OP_XOR_AI) c = C_XAI;
        if (op == OP_ROTL) c = C_ROL;
        if (op == OP_ROTR) c = C_ROR;
        if (op == OP_MOVE_AD) c = C_MAD;
        if ((op & MSK_PSEL) == OP_MOVE_AM) c = C_MAI;
        if ((op & MSK_WSEL) == OP_MOVE_RD) c = C_MRD;
        if ((op & MSK_WSEL) == OP_MOVE_RI) c = C_MRI;
        if (op == OP_MOVE_DA) c = C_MDA;
        if ((op & MSK_WSEL) == OP_MOVE_DR) c = C_MDR;
        if (op == OP_MOVE_DD) c = C_MDD;
        return c;
    endfunction

    function automatic alm_len_s alm_length(input alm_cls_e c);
        alm_len_s l;
        l = L_2B2C;
        case (c)
            C_NOP, C_ROL, C_ROR: l = L_1B1C;
            C_XAM, C_MAI:        l = L_1B2C;
            C_XDI, C_MDD:        l = L_3B3C;
            default:             l = L_2B2C;
        endcase
        return l;
    endfunction

endpackage

//--- testbench/accumulator_logic_move_ops_tb.sv
// Self-checking bench for the xor, rotate and move executor
`timescale 1ns/10ps
module accumulator_logic_move_ops_tb;
    import alm_pkg::*;
    logic        core_clk = 1'b0;
    logic        srst     = 1'b1;
    logic [15:0] code_addr;
    logic        code_rd;
    logic [7:0]  code_data;
    logic [7:0]  dmem_raddr;
    logic        dmem_rd;
    logic [7:0]  dmem_rdata;
    alm_wr_s     dmem_wr;
    logic [7:0]  acc;
    logic        carry;
    logic        instr_done;
    logic        illegal_op;
    int          fails = 0;
    int          comparisons = 0;
    int          cyc, nb, n_done;
    bit          pend;
    int          eb[$], ec[$];
    logic [7:0]  ea[$];
    logic        ek[$];

    always #4 core_clk = ~core_clk;

    alm_core dut (.core_clk(core_clk), .srst(srst), .code_addr(code_addr),
        .code_rd(code_rd), .code_data(code_data), .dmem_raddr(dmem_raddr),
        .dmem_rd(dmem_rd), .dmem_rdata(dmem_rdata), .dmem_wr(dmem_wr), .acc(acc),
        .carry(carry), .instr_done(instr_done), .illegal_op(illegal_op));

    alm_mem_model mem (.core_clk(core_clk), .code_addr(code_addr),
        .code_data(code_data), .dmem_raddr(dmem_raddr), .dmem_rd(dmem_rd),
        .dmem_rdata(dmem_rdata), .dmem_wr(dmem_wr));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic print_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic load(input logic [7:0] p[$]);
        foreach (mem.prog[i]) mem.prog[i] = 8'h00;
        foreach (mem.data[i]) mem.data[i] = 8'h00;
        foreach (p[i]) mem.prog[i] = p[i];
    endtask

    // One settled sample per cycle, taken at the falling edge
    task automatic step();
        if (pend) begin
            pend = 1'b0;
            comparisons++;
            if (acc !== ea[n_done-1] || carry !== ek[n_done-1]) begin
                fails++;
                $display("unexpected at %0t: acc or carry after instruction %0d", $time, n_done);
            end
        end
        if (n_done < ec.size()) begin
            cyc++;
            if (code_rd === 1'b1) nb++;
            comparisons++;
            if (illegal_op !== 1'b0) begin
                fails++;
                $display("unexpected at %0t: valid opcode flagged unknown", $time);
            end
            if (instr_done === 1'b1) begin
                comparisons++;
                if (cyc != ec[n_done] || nb != eb[n_done]) begin
                    fails++;
                    $display("unexpected at %0t: instruction %0d length", $time, n_done);
                end
                cyc = 0;
                nb = 0;
                pend = 1'b1;
                n_done++;
            end
        end
    endtask

    // Reset 8 cycles, then run until every listed instruction retired
    task automatic run();
        int t;
        // Reset at once, so the freshly loaded program never runs mid-stream
        srst <= 1'b1;
        repeat (8) @(negedge core_clk);
        srst <= 1'b0;
        cyc = 0;
        nb = 0;
        n_done = 0;
        pend = 1'b0;
        // First opcode cycle is already on the pins at release
        for (t = 0; t < 200 && (n_done < ec.size() || pend); t++) begin
            step();
            @(negedge core_clk);
        end
        if (t == 200) begin
            fails++;
            $display("unexpected at %0t: run timeout", $time);
            print_verdict();
        end
        // Past the program only zero bytes remain, one unknown opcode retired
        comparisons++;
        if (illegal_op !== 1'b1 || code_addr !== 16'(eb.sum() + 1)) begin
            fails++;
            $display("unexpected at %0t: fetch past program end wrong", $time);
        end
        repeat (3) @(negedge core_clk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_xor();
        load('{8'h48, 8'h20, 8'h14, 8'h5A, 8'h10, 8'h30, 8'h11, 8'h31, 8'hFF, 8'h12});
        mem.data[8'h20] = 8'h11;
        mem.data[8'h30] = 8'h0F;
        mem.data[8'h31] = 8'h33;
        eb = '{2, 2, 2, 3, 1};
        ec = '{2, 2, 2, 3, 2};
        ea = '{8'h00, 8'h5A, 8'h5A, 8'h5A, 8'h4B};
        ek = '{0, 0, 0, 0, 0};
        run();
        comparisons++;
        if (mem.data[8'h30] !== 8'h55) begin
            fails++;
            $display("unexpected at %0t: xor acc into direct", $time);
        end
        comparisons++;
        if (mem.data[8'h31] !== 8'hCC) begin
            fails++;
            $display("unexpected at %0t: xor imm into direct", $time);
        end
        $display("test xor done");
    endtask

    task automatic test_rot();
        load('{8'h14, 8'h81, 8'h20, 8'h20, 8'h21, 8'h21, 8'h21});
        eb = '{2, 1, 1, 1, 1, 1};
        ec = '{2, 1, 1, 1, 1, 1};
        ea = '{8'h81, 8'h02, 8'h05, 8'h02, 8'h81, 8'h40};
        ek = '{0, 1, 0, 1, 0, 1};
        run();
        $display("test rotate done");
    endtask

    task automatic test_mov();
        load('{8'h30, 8'h40, 8'h43, 8'h41, 8'h4D, 8'h77, 8'h50, 8'h50, 8'h5B, 8'h51,
               8'h5D, 8'h52, 8'h60, 8'h41, 8'h53, 8'h49, 8'h51, 8'h33, 8'h30, 8'h52});
        mem.data[8'h40] = 8'hA5;
        mem.data[8'h41] = 8'h3C;
        eb = '{2, 2, 2, 2, 2, 2, 3, 2, 1, 2};
        ec = '{2, 2, 2, 2, 2, 2, 3, 2, 2, 2};
        ea = '{8'hA5, 8'hA5, 8'hA5, 8'hA5, 8'hA5, 8'hA5, 8'hA5, 8'hA5, 8'h3C, 8'h77};
        ek = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
        run();
        comparisons++;
        if (mem.data[8'h50] !== 8'hA5) begin
            fails++;
            $display("unexpected at %0t: store acc", $time);
        end
        comparisons++;
        if (mem.data[8'h51] !== 8'h3C) begin
            fails++;
            $display("unexpected at %0t: store reg from direct", $time);
        end
        comparisons++;
        if (mem.data[8'h52] !== 8'h77) begin
            fails++;
            $display("unexpected at %0t: store reg from imm", $time);
        end
        comparisons++;
        if (mem.data[8'h53] !== 8'h3C) begin
            fails++;
            $display("unexpected at %0t: direct to direct", $time);
        end
        $display("test move done");
    endtask

    initial begin
        test_xor();
        test_rot();
        test_mov();
        print_verdict();
    end
endmodule // accumulator_logic_move_ops_tb

//--- testbench/alm_mem_model.sv
// Program and data memory model seen by the executor
`timescale 1ns/10ps
module alm_mem_model
    import alm_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic [15:0]  code_addr,
    output logic [7:0]        code_data,
    input  wire logic [7:0]   dmem_raddr,
    input  wire logic         dmem_rd,
    output logic [7:0]        dmem_rdata,
    input  wire alm_wr_s      dmem_wr
);
    logic [7:0] prog [256];
    logic [7:0] data [256];

    // Combinational fetch, same-cycle answer
    assign code_data  = prog[code_addr[7:0]];
    // Unread port shows inverted data, never a stale match
    assign dmem_rdata = dmem_rd ? data[dmem_raddr] : ~data[dmem_raddr];

    // Write commits at the edge so the next read sees it
    always @(posedge core_clk) begin
        if (dmem_wr.we === 1'b1) begin
            data[dmem_wr.addr] <= dmem_wr.data;
        end
    end
endmodule // alm_mem_model
